// ==== dv/bbm_host_model.sv ====
module bbm_host_model (
    input wire logic mclk, // Clock
    output logic modeWrite = 1'h0, // Mode load strobe
    output logic switchoverSelectIn = 1'h0, // Select bit value
    output logic serialInhibitIn = 1'h0 // Inhibit bit value
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic write_mode(input logic inh, input logic sel);
        @(posedge mclk) #1;
        {modeWrite, serialInhibitIn, switchoverSelectIn} = {1'h1, inh, sel};
        @(posedge mclk) #1;
        modeWrite = 1'h0;
    endtask
endmodule

// ==== dv/bbm_mode_select_props.sv ====
module bbm_mode_select_props #(parameter int FILTER_COUNT = 4) (
    input wire logic mclk,                      // Clock
    input wire logic rst,                       // Synchronous reset
    input wire logic modeWrite,                 // Mode load strobe
    input wire logic switchoverSelectIn,        // Select value
    input wire logic serialInhibitIn,           // Inhibit value
    input wire logic supplyBelowTrip,           // Trip comparator
    input wire logic supplyBelowBattery,        // Battery comparator
    input wire logic alarmFreqRequest,          // Pin pull request
    input wire logic onBattery,                 // Backup state
    input wire logic serialInhibitOnBatteryBit, // Stored inhibit bit
    input wire logic switchoverSelectBit,       // Stored select bit
    input wire logic serialEnable,              // Serial allowed
    input wire logic nvmEnable,                 // Memory allowed
    input wire logic alarmFreqOutputOe_n,       // Pin drive enable
    input wire bbm_pkg::bbm_mode_type mode      // Decoded mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Eight steady samples outlast the filter plus the state register for counts up to 6
    sequence s_legacy_low; (switchoverSelectBit && supplyBelowBattery)[*8]; endsequence
    sequence s_both_low; (supplyBelowTrip && supplyBelowBattery)[*8]; endsequence
    sequence s_std_high; (!switchoverSelectBit && !supplyBelowTrip)[*8]; endsequence
    a_reset_default: assert property ($past(rst) |-> mode == 2'h0 && !onBattery)
        else $error("bad state after reset");
    a_mode_load: assert property (modeWrite |=> mode ==
        {$past(serialInhibitIn), $past(switchoverSelectIn)}) else $error("bad mode load");
    a_serial_gate: assert property (
        serialEnable == !(onBattery && serialInhibitOnBatteryBit))
        else $error("bad serial enable");
    a_nvm_block: assert property (nvmEnable == !onBattery) else $error("bad nvm");
    a_alarm_drive: assert property (
        1'h1 |=> alarmFreqOutputOe_n == !$past(alarmFreqRequest))
        else $error("alarm pin stuck");
    a_legacy_entry: assert property (s_legacy_low |-> onBattery)
        else $error("no legacy entry");
    a_std_entry: assert property (s_both_low |-> onBattery) else $error("no entry");
    a_std_stay: assert property (s_std_high |-> !onBattery)
        else $error("early entry");
endmodule
bind bbm_mode_select bbm_mode_select_props #(.FILTER_COUNT(FILTER_COUNT)) props_i (.*);

// ==== dv/tb_bbm_mode_select.sv ====
module tb_bbm_mode_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, rst = 1'h1, alarmFreqRequest = 1'h0;
    logic supplyBelowTrip = 1'h0, supplyBelowBattery = 1'h0;
    logic modeWrite, switchoverSelectIn, serialInhibitIn, switchoverSelectBit;
    logic serialInhibitOnBatteryBit, onBattery, serialEnable, nvmEnable;
    logic alarmFreqOutput, alarmFreqOutputOe_n, b;
    bbm_pkg::bbm_mode_type mode;
    int fails = 0, cmp_count = 0;
    logic [4:0] r;
    always #20 mclk = ~mclk;
    bbm_host_model bbm_host_model_i (.*);
    bbm_mode_select #(.FILTER_COUNT(2)) bbm_mode_select_i (.*);
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %b expected %b", $time, got, exp);
        end
    endtask
    function automatic logic exp_bat(input logic [4:0] v);
        return v[2] ? v[0] : (v[1] && v[0]);
    endfunction
    task automatic wrap_up;
        $display("Mismatches %0d of %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #160000;
        fails++;
        wrap_up();
    end
    initial begin
        void'($urandom(48));
        repeat (6) @(posedge mclk);
        #1 rst = 1'h0;
        chk(mode, 2'h0);
        chk({onBattery, nvmEnable}, 2'h1);
        // All sixteen mode and comparator pairs first, then random mixes
        for (int i = 0; i < 40; i++) begin
            r = (i < 16) ? 5'(i) : 5'($urandom);
            bbm_host_model_i.write_mode(r[3], r[2]);
            {supplyBelowTrip, supplyBelowBattery, alarmFreqRequest} = {r[1], r[0], r[4]};
            repeat (8) @(posedge mclk);
            #1 b = exp_bat(r);
            chk(mode, r[3:2]);
            chk({serialInhibitOnBatteryBit, switchoverSelectBit}, r[3:2]);
            chk({onBattery, nvmEnable}, {b, !b});
            chk({1'h0, serialEnable}, {1'h0, !(r[3] && b)});
            chk({alarmFreqOutputOe_n, alarmFreqOutput}, {!r[4], 1'h0});
        end
        wrap_up();
    end
endmodule

// ==== hdl/bbm_filter.sv ====
module bbm_filter #(
    parameter int COUNT = bbm_pkg::DEBOUNCE_CYCLES
) (
    input wire logic mclk,   // System clock
    input wire logic rst,    // Synchronous reset, active high
    input wire logic rawIn,  // Raw comparator level
    output logic filtOut     // Filtered level
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_filtOut;

    // Glitches on the analog trip points must not bounce the supply switch
    always_comb begin
        next_cnt = '0;
        next_filtOut = filtOut;
        if (rawIn != filtOut) begin
            if (cnt == LAST) begin
                next_filtOut = rawIn;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt <= '0;
            filtOut <= 1'b0;
        end else begin
            cnt <= next_cnt;
            filtOut <= next_filtOut;
        end
    end
endmodule

// ==== hdl/bbm_mode_select.sv ====
// Notes on behaviour
// RULE1 - Bits 0,0: threshold switchover, serial interface stays usable on battery.
// RULE2 - Bits inhibit 0, select 1: legacy switchover below battery, serial stays usable.
// RULE3 - Bits inhibit 1, select 0: threshold switchover, serial disabled on battery.
// RULE4 - Bits 1,1: legacy switchover, serial disabled on battery.
// RULE5 - Standard switchover trips below the lower of trip threshold and battery.
// RULE6 - Alarm/frequency open-drain output keeps working on battery in every mode.
// RULE7 - Nonvolatile memory reads and writes are refused while on battery.
// RULE8 - After power-up the mode is standard switchover until software changes it.
module bbm_mode_select #(
    parameter int FILTER_COUNT = bbm_pkg::DEBOUNCE_CYCLES
) (
    input wire logic mclk,                  // 25 MHz clock
    input wire logic rst,                   // Synchronous reset, active high
    input wire logic modeWrite,             // One-cycle strobe loading the mode bits
    input wire logic switchoverSelectIn,    // New switchover select bit value
    input wire logic serialInhibitIn,       // New serial-inhibit-on-battery value
    input wire logic supplyBelowTrip,       // Comparator: supply below trip threshold
    input wire logic supplyBelowBattery,    // Comparator: supply below battery
    input wire logic alarmFreqRequest,      // Alarm/frequency logic wants pin low
    output logic switchoverSelectBit,       // Stored switchover select bit
    output logic serialInhibitOnBatteryBit, // Stored serial inhibit bit
    output bbm_pkg::bbm_mode_type mode,     // Decoded mode A..D
    output logic onBattery,                 // Device running from battery
    output logic serialEnable,              // Serial interface may operate
    output logic nvmEnable,                 // Nonvolatile memory access allowed
    output logic alarmFreqOutput,           // Open-drain pin output value (always 0)
    output logic alarmFreqOutputOe_n        // Pin drive enable, low drives low
);
    bbm_pkg::bbm_state_type state;
    bbm_pkg::bbm_state_type next_state;
    logic next_switchoverSelectBit;
    logic next_serialInhibitOnBatteryBit;
    logic belowTripF;
    logic belowBatF;
    logic next_serialEnable;
    logic next_nvmEnable;
    logic next_onBattery;
    logic next_oe_n;
    logic enterCond;

    bbm_filter #(.COUNT(FILTER_COUNT)) uTrip (
        .mclk(mclk),
        .rst(rst),
        .rawIn(supplyBelowTrip),
        .filtOut(belowTripF)
    );

    bbm_filter #(.COUNT(FILTER_COUNT)) uBat (
        .mclk(mclk),
        .rst(rst),
        .rawIn(supplyBelowBattery),
        .filtOut(belowBatF)
    );

    always_comb begin
        next_switchoverSelectBit = switchoverSelectBit;
        next_serialInhibitOnBatteryBit = serialInhibitOnBatteryBit;
        if (modeWrite) begin
            next_switchoverSelectBit = switchoverSelectIn;
            next_serialInhibitOnBatteryBit = serialInhibitIn;
        end
    end

    always_comb begin
        mode = bbm_pkg::bbm_mode_type'({serialInhibitOnBatteryBit, switchoverSelectBit});
    end

    always_comb begin
        // Supply below the lower of two levels means below both comparators
        enterCond = 1'b0;
        unique case (mode)
            bbm_pkg::BBM_MODE_A: enterCond = belowTripF && belowBatF; // see RULE1 see RULE5
            bbm_pkg::BBM_MODE_B: enterCond = belowBatF;               // see RULE2
            bbm_pkg::BBM_MODE_C: enterCond = belowTripF && belowBatF; // see RULE3 see RULE5
            bbm_pkg::BBM_MODE_D: enterCond = belowBatF;               // see RULE4
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            bbm_pkg::BBM_ON_SUPPLY: begin
                if (enterCond) begin
                    next_state = bbm_pkg::BBM_ON_BATTERY;
                end
            end
            bbm_pkg::BBM_ON_BATTERY: begin
                if (!enterCond) begin
                    next_state = bbm_pkg::BBM_ON_SUPPLY;
                end
            end
        endcase
        next_onBattery = (next_state == bbm_pkg::BBM_ON_BATTERY);
        // Serial is cut only when inhibit is set and we are on battery
        next_serialEnable = !(next_onBattery && next_serialInhibitOnBatteryBit); // see RULE3 see RULE4
        next_nvmEnable = !next_onBattery; // see RULE7
        // Pin stays alive on battery; a pull-up to the battery is the board's job
        next_oe_n = !alarmFreqRequest; // see RULE6
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            switchoverSelectBit <= bbm_pkg::RST_SWITCH_SELECT;        // see RULE8
            serialInhibitOnBatteryBit <= bbm_pkg::RST_SERIAL_INHIBIT; // see RULE8
            state <= bbm_pkg::BBM_ON_SUPPLY;
            onBattery <= 1'b0;
            serialEnable <= 1'b1;
            nvmEnable <= 1'b1;
            alarmFreqOutputOe_n <= 1'b1;
        end else begin
            switchoverSelectBit <= next_switchoverSelectBit;
            serialInhibitOnBatteryBit <= next_serialInhibitOnBatteryBit;
            state <= next_state;
            onBattery <= next_onBattery;
            serialEnable <= next_serialEnable;
            nvmEnable <= next_nvmEnable;
            alarmFreqOutputOe_n <= next_oe_n;
        end
    end

    assign alarmFreqOutput = 1'b0;
endmodule

// ==== hdl/bbm_pkg.sv ====
package bbm_pkg;
    // Mode bit positions within the two-bit mode word {serialInhibit, switchSelect}
    localparam int MODE_SWITCH_POS = 0;
    localparam int MODE_INHIBIT_POS = 1;
    // Reset values: standard switchover, serial interface kept alive on battery
    localparam logic RST_SWITCH_SELECT = 1'h0;
    localparam logic RST_SERIAL_INHIBIT = 1'h0;
    // Consecutive agreeing comparator samples before the supply state changes
    localparam int DEBOUNCE_CYCLES = 4;

    typedef enum logic [1:0] {
        BBM_MODE_A,
        BBM_MODE_B,
        BBM_MODE_C,
        BBM_MODE_D
    } bbm_mode_type;

    typedef enum {
        BBM_ON_SUPPLY,
        BBM_ON_BATTERY
    } bbm_state_type;
endpackage
